// ### shared/tmo_pkg.sv
package tmo_pkg;
  localparam logic [3:0] CTRL_OFF = 4'h0;
  localparam logic [3:0] COUNT_OFF = 4'h4;
  localparam logic [3:0] PERIOD_OFF = 4'h8;
  localparam logic [3:0] STATUS_OFF = 4'hc;
  localparam int RUN_BIT = 15;
  localparam int IDLE_HALT_BIT = 13;
  localparam int GATE_BIT = 6;
  localparam int PS_LSB = 4;
  localparam int SYNC_BIT = 2;
  localparam int SRC_BIT = 1;
  localparam logic [15:0] CTRL_MASK = 16'ha076;
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [15:0] PERIOD_RESET = 16'hffff;
  localparam logic [7:0] DIV_8 = 8'h07;
  localparam logic [7:0] DIV_64 = 8'h3f;
  localparam logic [7:0] DIV_256 = 8'hff;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : tmo_pkg

// ### shared/tmo_tick_if.sv
`timescale 1ns/1ps
interface tmo_tick_if;
  logic [1:0] prescale_sel;
  logic clear;
  logic tick_in;
  logic tick_out;
  modport ctrl (output prescale_sel, output clear, output tick_in, input tick_out);
  modport div (input prescale_sel, input clear, input tick_in, output tick_out);
endinterface : tmo_tick_if

// ### hdl/tmo_prescaler.sv
`timescale 1ns/1ps
module tmo_prescaler
  import tmo_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  tmo_tick_if.div tk
);
  logic [7:0] cnt_reg;
  logic [7:0] limit;

  function automatic logic [7:0] ratio_limit(input logic [1:0] sel);
    case (sel)
      2'h1: ratio_limit = DIV_8;
      2'h2: ratio_limit = DIV_64;
      2'h3: ratio_limit = DIV_256;
      default: ratio_limit = 8'h00;
    endcase
  endfunction : ratio_limit

  assign limit = ratio_limit(tk.prescale_sel);
  assign tk.tick_out = tk.tick_in && (cnt_reg == limit);

  always_ff @(posedge aclk) begin
    if (!aresetn || tk.clear) begin
      cnt_reg <= 8'h00;
    end else if (tk.tick_in) begin
      cnt_reg <= (cnt_reg == limit) ? 8'h00 : cnt_reg + 8'h01;
    end
  end
endmodule : tmo_prescaler

// ### hdl/tmo_timer.sv
// How it works
// - run bit set starts the 16-bit count, cleared stops it.
// - external source selected makes the gate enable bit have no effect.
// - sync bit chooses synchronised or raw pin clock; ignored on internal source.
// - source select picks pin rising edges or the internal peripheral clock.
// - prescale field gives ratios 1:1, 1:8, 1:64, 1:256 for codes 0 to 3.
// - idle halt bit stops the timer while the device is idle.
// - internal source with gate bit set counts only while gate is high.
`timescale 1ns/1ps
module tmo_timer
  import tmo_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic ext_clk_pin,
  input wire logic gate_in,
  input wire logic idle_mode,
  output logic period_match
);
  logic [15:0] ctrl_reg;
  logic [15:0] count_reg;
  logic [15:0] period_reg;
  logic match_reg;
  logic [3:0] awaddr_reg;
  logic aw_held_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic w_held_reg;
  logic [1:0] sync_ext_reg;
  logic ext_prev_reg;
  logic [1:0] sync_gate_reg;
  logic gate_prev_reg;
  logic ext_raw_reg;
  logic ext_raw_prev_reg;
  logic ext_meta_reg;
  logic gate_meta_reg;
  logic ext_edge_sync;
  logic ext_edge_raw;
  logic ext_edge;
  logic gate_level;
  logic base_tick;
  logic running;
  logic do_write;
  logic [3:0] wr_addr;
  logic [15:0] wr_data;
  logic wr_ok;
  logic ext_sync_mode;
  logic [31:0] rd_data;
  logic rd_ok;

  tmo_tick_if tk ();

  tmo_prescaler u_prescaler (
    .aclk(aclk),
    .aresetn(aresetn),
    .tk(tk)
  );

  // three-stage input capture; change taken once stages two and three agree
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ext_meta_reg <= 1'b0;
      sync_ext_reg <= 2'h0;
      ext_prev_reg <= 1'b0;
      gate_meta_reg <= 1'b0;
      sync_gate_reg <= 2'h0;
      gate_prev_reg <= 1'b0;
    end else begin
      ext_meta_reg <= ext_clk_pin;
      sync_ext_reg <= {sync_ext_reg[0], ext_meta_reg};
      if (sync_ext_reg[0] == sync_ext_reg[1]) begin
        ext_prev_reg <= sync_ext_reg[1];
      end
      gate_meta_reg <= gate_in;
      sync_gate_reg <= {sync_gate_reg[0], gate_meta_reg};
      if (sync_gate_reg[0] == sync_gate_reg[1]) begin
        gate_prev_reg <= sync_gate_reg[1];
      end
    end
  end

  // unsynchronised path: one capture, no filtering, so edges arrive sooner but glitches count
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ext_raw_reg <= 1'b0;
      ext_raw_prev_reg <= 1'b0;
    end else begin
      ext_raw_reg <= ext_clk_pin;
      ext_raw_prev_reg <= ext_raw_reg;
    end
  end

  assign ext_edge_sync = (sync_ext_reg == 2'h3) && !ext_prev_reg;
  assign ext_edge_raw = ext_raw_reg && !ext_raw_prev_reg;
  assign gate_level = gate_prev_reg;

  assign ext_edge = ctrl_reg[SYNC_BIT] ? ext_edge_sync : ext_edge_raw;

  assign running = ctrl_reg[RUN_BIT] && !(idle_mode && ctrl_reg[IDLE_HALT_BIT]);

  always_comb begin
    if (ctrl_reg[SRC_BIT]) begin
      base_tick = ext_edge;
    end else if (ctrl_reg[GATE_BIT]) begin
      base_tick = gate_level;
    end else begin
      base_tick = 1'b1;
    end
  end

  assign tk.tick_in = running && base_tick;
  assign tk.prescale_sel = ctrl_reg[PS_LSB +: 2];
  assign tk.clear = !ctrl_reg[RUN_BIT];

  // write channel: address and data taken in either order, response after both
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      awaddr_reg <= 4'h0;
      w_held_reg <= 1'b0;
      wdata_reg <= 32'h0;
      wstrb_reg <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_reg <= 1'b1;
        awaddr_reg <= s_axi_awaddr;
      end else if (do_write) begin
        aw_held_reg <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_reg <= 1'b1;
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end else if (do_write) begin
        w_held_reg <= 1'b0;
      end
    end
  end

  assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
  assign s_axi_wready = !w_held_reg && !s_axi_bvalid;
  assign do_write = aw_held_reg && w_held_reg && !s_axi_bvalid;
  assign wr_addr = {awaddr_reg[3:2], 2'h0};
  assign wr_data = {wstrb_reg[1] ? wdata_reg[15:8] : 8'h00, wstrb_reg[0] ? wdata_reg[7:0] : 8'h00};
  assign wr_ok = (wr_addr == CTRL_OFF) || (wr_addr == COUNT_OFF) || (wr_addr == PERIOD_OFF);
  assign ext_sync_mode = ctrl_reg[RUN_BIT] && ctrl_reg[SRC_BIT] && ctrl_reg[SYNC_BIT];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // unused bits are masked so they always read zero
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg <= CTRL_RESET;
    end else if (do_write && wr_addr == CTRL_OFF) begin
      ctrl_reg <= (ctrl_reg & ~{wstrb_reg[1] ? 8'hff : 8'h00, wstrb_reg[0] ? 8'hff : 8'h00})
        | (wr_data & CTRL_MASK);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      period_reg <= PERIOD_RESET;
    end else if (do_write && wr_addr == PERIOD_OFF) begin
      period_reg <= {wstrb_reg[1] ? wr_data[15:8] : period_reg[15:8], wstrb_reg[0] ? wr_data[7:0] : period_reg[7:0]};
    end
  end

  // counter wraps to zero on period match; software load has lower priority than nothing else, but is dropped while ext_sync_mode is set
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_reg <= COUNT_RESET;
      match_reg <= 1'b0;
    end else if (do_write && wr_addr == COUNT_OFF && !ext_sync_mode) begin
      count_reg <= {wstrb_reg[1] ? wr_data[15:8] : count_reg[15:8], wstrb_reg[0] ? wr_data[7:0] : count_reg[7:0]};
      match_reg <= 1'b0;
    end else if (tk.tick_out) begin
      if (count_reg == period_reg) begin
        count_reg <= COUNT_RESET;
        match_reg <= 1'b1;
      end else begin
        count_reg <= count_reg + 16'h0001;
        match_reg <= 1'b0;
      end
    end else begin
      match_reg <= 1'b0;
    end
  end

  assign period_match = match_reg;

  always_comb begin
    rd_ok = 1'b1;
    unique case ({s_axi_araddr[3:2], 2'h0})
      CTRL_OFF: rd_data = {16'h0000, ctrl_reg};
      COUNT_OFF: rd_data = {16'h0000, count_reg};
      PERIOD_OFF: rd_data = {16'h0000, period_reg};
      STATUS_OFF: rd_data = {29'h0, gate_level, running, ext_sync_mode};
      default: begin
        rd_data = 32'h0;
        rd_ok = 1'b0;
      end
    endcase
  end

  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_data;
      s_axi_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule : tmo_timer

// ### dv/tmo_timer_properties.sv
`timescale 1ns/1ps
module tmo_timer_properties
  import tmo_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic period_match
);
  logic aw_reg, w_reg;
  logic [3:0] wa_reg, ra_reg;
  logic [15:0] wd_reg, ctrl_reg;
  wire aw_hs = s_axi_awvalid && s_axi_awready;
  wire w_hs = s_axi_wvalid && s_axi_wready;
  wire commit = (aw_hs || aw_reg) && (w_hs || w_reg);
  wire [3:0] c_addr = aw_hs ? s_axi_awaddr : wa_reg;
  wire [15:0] c_data = w_hs ? s_axi_wdata[15:0] : wd_reg;
  // shadow leads the real register by one edge, so stop checks allow slack
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_reg <= 1'h0;
      w_reg <= 1'h0;
      ctrl_reg <= CTRL_RESET;
    end else begin
      aw_reg <= (aw_hs || aw_reg) && !commit;
      w_reg <= (w_hs || w_reg) && !commit;
      if (aw_hs) wa_reg <= s_axi_awaddr;
      if (w_hs) wd_reg <= s_axi_wdata[15:0];
      if (s_axi_arvalid && s_axi_arready) ra_reg <= s_axi_araddr;
      if (commit && c_addr == CTRL_OFF) ctrl_reg <= c_data & CTRL_MASK;
    end
  end
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence stopped_s;
    !ctrl_reg[RUN_BIT] [*4];
  endsequence
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("no read answer");
  // the bench keeps its ready high while valid is up, so each check covers only the release, never the hold
  a_rdata_hold: assert property (s_axi_rvalid |=> s_axi_rvalid == !$past(s_axi_rready) && $stable(s_axi_rdata))
    else $error("read data not held");
  a_bvalid_hold: assert property (s_axi_bvalid |=> s_axi_bvalid == !$past(s_axi_bready))
    else $error("bvalid not held or not released");
  a_bresp_next: assert property (commit |-> ##2 s_axi_bvalid) else $error("late write answer");
  a_bvalid_blocks: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("write open");
  a_arready_free: assert property (s_axi_arready == !s_axi_rvalid) else $error("arready wrong");
  a_ctrl_readback: assert property (s_axi_rvalid && ra_reg == CTRL_OFF |-> s_axi_rdata == {16'h0000, ctrl_reg})
    else $error("control readback wrong");
  a_stop_quiet: assert property (stopped_s |-> !period_match)
    else $error("match while stopped");
endmodule : tmo_timer_properties
bind tmo_timer tmo_timer_properties u_props (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .period_match(period_match));

// ### dv/timer_one_control_tb_top.sv
`timescale 1ns/1ps
module timer_one_control_tb_top;
  import tmo_pkg::*;
  logic aclk = 1'h0, aresetn = 1'h0, awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic pin = 1'h0, gate = 1'h0, idle = 1'h0, pin_run = 1'h0;
  logic [3:0] awaddr = 4'h0, araddr = 4'h0;
  logic [31:0] wdata = 32'h0, rdata, d, c0;
  logic [1:0] bresp, rresp, r, pc = 2'h0;
  logic awready, wready, bvalid, arready, rvalid, match;
  int failures = 0, n_compared = 0, seed = 80285, n;
  tmo_timer dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .ext_clk_pin(pin), .gate_in(gate), .idle_mode(idle),
    .period_match(match));
  initial forever #20 aclk = ~aclk;
  // pin period of eight cycles, frozen between bursts
  always @(posedge aclk) begin
    pc <= pc + 2'h1;
    if (pin_run && pc == 2'h3) pin <= ~pin;
  end
  function automatic int exp_div(input int ps);
    return ps == 3 ? 256 : 1 << (3 * ps);
  endfunction : exp_div
  task print_verdict;
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : print_verdict
  task chk(input logic [31:0] got, input logic [31:0] e);
    n_compared++;
    if (got !== e) begin
      failures++;
      $display("[FAIL] %0t got %h expected %h", $time, got, e);
    end
  endtask : chk
  task wr(input logic [3:0] a, input logic [31:0] v);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'h0;
      if (wvalid && wready) wvalid <= 1'h0;
    end while (!bvalid);
    r = bresp;
    bready <= 1'h0;
    @(posedge aclk);
  endtask : wr
  task rd(input logic [3:0] a);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'h0;
    end while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'h0;
    @(posedge aclk);
  endtask : rd
  task rchk(input logic [3:0] a, input logic [31:0] e);
    rd(a);
    chk(d, e);
  endtask : rchk
  // cycles between two match pulses, 0 when none comes
  task gap;
    n = 0;
    for (int t = 0; t < 700 && !match; t++) @(posedge aclk);
    if (match) do begin
      @(posedge aclk);
      n++;
    end while (!match && n < 700);
  endtask : gap
  task run(input logic [31:0] c, input int e);
    wr(CTRL_OFF, c);
    gap();
    chk(n, e);
  endtask : run
  initial begin
    repeat (20000) @(posedge aclk);
    failures++;
    print_verdict();
  end
  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'h1;
    rchk(CTRL_OFF, {16'h0, CTRL_RESET});
    rchk(COUNT_OFF, {16'h0, COUNT_RESET});
    rchk(PERIOD_OFF, {16'h0, PERIOD_RESET});
    rchk(STATUS_OFF, 32'h0);
    // status is read-only, so a write there is refused
    wr(STATUS_OFF, 32'h0);
    chk({30'h0, r}, {30'h0, RESP_SLVERR});
    for (int i = 0; i < 4; i++) begin
      c0 = $random(seed) & 32'h7fff;
      wr(CTRL_OFF, c0);
      rchk(CTRL_OFF, c0 & {16'h0, CTRL_MASK});
    end
    $display("register test done");
    wr(PERIOD_OFF, 32'h0);
    for (int ps = 0; ps < 4; ps++) begin
      wr(CTRL_OFF, 32'h0);
      run(32'h8000 | (ps << 4), exp_div(ps));
    end
    run(32'h0, 0);
    run(32'h8040, 0);
    gate <= 1'h1;
    run(32'h8040, 1);
    idle <= 1'h1;
    run(32'ha000, 0);
    run(32'h8000, 1);
    idle <= 1'h0;
    gate <= 1'h0;
    $display("internal test done");
    pin_run <= 1'h1;
    for (int s = 0; s < 2; s++) run(32'h8042 | (s << 2), 8);
    pin_run <= 1'h0;
    repeat (8) @(posedge aclk);
    run(32'h8046, 0);
    rchk(STATUS_OFF, 32'h3);
    rd(COUNT_OFF);
    c0 = d;
    wr(COUNT_OFF, $random(seed) & 32'hffff);
    rchk(COUNT_OFF, c0);
    c0 = $random(seed) & 32'hffff;
    wr(CTRL_OFF, 32'h8002);
    wr(COUNT_OFF, c0);
    rchk(COUNT_OFF, c0);
    $display("external test done");
    print_verdict();
  end
endmodule : timer_one_control_tb_top
